// ===== rtl/cfl_flash_port.sv
// Functional notes
// - chip select is active low: port enabled while low, off while high
// - while still selected after configuration, port keeps driving array words
// - address latch enable is active low: address captured while low
// - at configuration start the starting read address loads the counter
// - latch enable stays high in configuration; other addresses then ignored
// - latch enable activity is ignored while chip select is high
// - one 16-bit word driven after each rising clock edge
// - starting address is zero from address lines resting low
`timescale 1ns/100ps
`default_nettype none
module cfl_flash_port
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic configuration_clock_in,
	input wire logic chip_select_n_in,
	input wire logic latch_enable_n_in,
	input wire logic [cfl_pkg::ADDR_W-1:0] address_in,
	input wire logic [cfl_pkg::DATA_W-1:0] dq_in,
	output logic [cfl_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe_n_out,
	input wire logic prog_we_in,
	input wire logic [cfl_pkg::MEM_AW-1:0] prog_addr_in,
	input wire logic [cfl_pkg::DATA_W-1:0] prog_data_in,
	output logic stream_active_out
);
	// array word index from a full counter value
	function automatic logic [cfl_pkg::MEM_AW-1:0] word_idx(input logic [cfl_pkg::ADDR_W-1:0] a);
		return a[cfl_pkg::MEM_AW-1:0];
	endfunction

	// array: written only on the system clock, read only on the link clock
	logic [cfl_pkg::DATA_W-1:0] mem [cfl_pkg::MEM_DEPTH];

	cfl_sync_if sync_if ();

	cfl_link_sync u_sync
	(
		.link_clk_in(configuration_clock_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.chip_select_n_in(chip_select_n_in),
		.latch_enable_n_in(latch_enable_n_in),
		.address_in(address_in),
		.sync_if(sync_if)
	);

	// link-domain stream flag, declared ahead of the status crossing that reads it
	logic stream_r;
	logic stream_nxt;

	// system domain: array loading port and link status readback
	logic act_meta_r;
	logic act_meta_nxt;
	logic act_r;
	logic act_nxt;

	always_comb
	begin
		act_meta_nxt = act_meta_r;
		act_nxt = act_r;
		if (rst_in)
		begin
			act_meta_nxt = 1'b0;
			act_nxt = 1'b0;
		end
		else if (ce_in)
		begin
			act_meta_nxt = stream_r;
			act_nxt = act_meta_r;
		end
	end

	// loading is a plain write; the array has no reset, as a real one has none
	always_ff @(posedge clk_sys_in)
	begin
		act_meta_r <= act_meta_nxt;
		act_r <= act_nxt;
		if (ce_in && prog_we_in)
		begin
			mem[prog_addr_in] <= prog_data_in;
		end
	end

	assign stream_active_out = act_r;

	// link domain: read port state, address counter and data pins
	cfl_pkg::cfl_state_t state_r;
	cfl_pkg::cfl_state_t state_nxt;
	logic [cfl_pkg::ADDR_W-1:0] addr_r;
	logic [cfl_pkg::ADDR_W-1:0] addr_nxt;
	logic [cfl_pkg::DATA_W-1:0] dq_r;
	logic [cfl_pkg::DATA_W-1:0] dq_nxt;
	logic oe_n_r;
	logic oe_n_nxt;
	logic [cfl_pkg::DATA_W-1:0] rd_word;

	assign rd_word = mem[word_idx(addr_r)];

	always_comb
	begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		dq_nxt = dq_r;
		oe_n_nxt = oe_n_r;
		if (sync_if.rst)
		begin
			state_nxt = cfl_pkg::ST_DESEL;
			addr_nxt = cfl_pkg::START_ADDR;
			dq_nxt = cfl_pkg::DATA_IDLE;
			oe_n_nxt = cfl_pkg::OE_RELEASE;
		end
		else if (sync_if.ce)
		begin
			if (!sync_if.sel)
			begin
				// deselected: pins released, latch enable ignored, counter held
				state_nxt = cfl_pkg::ST_DESEL;
				oe_n_nxt = cfl_pkg::OE_RELEASE;
			end
			else
			begin
				case (state_r)
					cfl_pkg::ST_DESEL:
					begin
						// selection opens a sequence: counter takes the resting lines
						addr_nxt = sync_if.addr;
						state_nxt = sync_if.latch_low ? cfl_pkg::ST_LATCH : cfl_pkg::ST_STREAM;
					end
					cfl_pkg::ST_STREAM:
					begin
						// lines on the address pins cannot disturb the counter here
						dq_nxt = rd_word;
						addr_nxt = cfl_pkg::ADDR_W'(addr_r + cfl_pkg::ADDR_STEP);
						oe_n_nxt = cfl_pkg::OE_DRIVE;
						if (sync_if.latch_low)
						begin
							state_nxt = cfl_pkg::ST_LATCH;
						end
					end
					cfl_pkg::ST_LATCH:
					begin
						// transparent latch for asynchronous accessors
						addr_nxt = sync_if.addr;
						dq_nxt = rd_word;
						oe_n_nxt = cfl_pkg::OE_DRIVE;
						if (!sync_if.latch_low)
						begin
							state_nxt = cfl_pkg::ST_STREAM;
						end
					end
					default:
					begin
						state_nxt = cfl_pkg::ST_DESEL;
					end
				endcase
			end
		end
	end

	// stream flag only for the status crossing; it is a single level
	always_comb
	begin
		stream_nxt = (state_nxt == cfl_pkg::ST_STREAM);
	end

	always_ff @(posedge configuration_clock_in)
	begin
		state_r <= state_nxt;
		addr_r <= addr_nxt;
		dq_r <= dq_nxt;
		oe_n_r <= oe_n_nxt;
		stream_r <= stream_nxt;
	end

	assign dq_out = dq_r;
	assign dq_oe_n_out = oe_n_r;

	// checks on the link domain; the status cover c_status_seen samples on the system clock
	logic run;
	assign run = sync_if.ce && !sync_if.rst;

	a_desel_release: assert property (@(posedge configuration_clock_in)
		disable iff (sync_if.rst) (run && !sync_if.sel) |=> (dq_oe_n_out && state_r == cfl_pkg::ST_DESEL))
		else $error("port did not release pins when deselected");
	a_desel_hold_addr: assert property (@(posedge configuration_clock_in)
		disable iff (sync_if.rst) (run && !sync_if.sel) |=> $stable(addr_r))
		else $error("counter moved while deselected");
	a_start_load: assert property (@(posedge configuration_clock_in)
		disable iff (sync_if.rst)
		(run && sync_if.sel && state_r == cfl_pkg::ST_DESEL) |=> (addr_r == $past(sync_if.addr)))
		else $error("start address not loaded on selection");
	a_stream_drive: assert property (@(posedge configuration_clock_in)
		disable iff (sync_if.rst)
		(run && sync_if.sel && state_r == cfl_pkg::ST_STREAM) |=> (!dq_oe_n_out))
		else $error("selected port not driving data");
	a_stream_word: assert property (@(posedge configuration_clock_in)
		disable iff (sync_if.rst)
		(run && sync_if.sel && state_r == cfl_pkg::ST_STREAM) |=> (dq_out == $past(rd_word)))
		else $error("wrong word on data pins");
	a_stream_step: assert property (@(posedge configuration_clock_in)
		disable iff (sync_if.rst)
		(run && sync_if.sel && state_r == cfl_pkg::ST_STREAM)
		##1 (run && sync_if.sel && state_r == cfl_pkg::ST_STREAM)
		|=> (addr_r == cfl_pkg::ADDR_W'($past(addr_r, 2) + 2)))
		else $error("counter did not advance one word per edge");
	a_latch_follow: assert property (@(posedge configuration_clock_in)
		disable iff (sync_if.rst)
		(run && sync_if.sel && state_r == cfl_pkg::ST_LATCH) |=> (addr_r == $past(sync_if.addr)))
		else $error("open latch did not follow address lines");
	a_addr_ignored: assert property (@(posedge configuration_clock_in)
		disable iff (sync_if.rst)
		(run && sync_if.sel && !sync_if.latch_low && state_r == cfl_pkg::ST_STREAM)
		|=> (state_r == cfl_pkg::ST_STREAM && addr_r != $past(sync_if.addr) || $past(sync_if.addr)
		== cfl_pkg::ADDR_W'($past(addr_r) + cfl_pkg::ADDR_STEP)))
		else $error("address lines reached the counter with latch closed");
	a_zero_start: assert property (@(posedge configuration_clock_in)
		disable iff (sync_if.rst)
		(run && sync_if.sel && state_r == cfl_pkg::ST_DESEL && sync_if.addr == cfl_pkg::START_ADDR)
		|=> (addr_r == cfl_pkg::START_ADDR) ##1 (!run || !sync_if.sel || state_r != cfl_pkg::ST_STREAM
		|| dq_out == mem[0]))
		else $error("sequence did not begin at word zero");

	c_stream_four: cover property (@(posedge configuration_clock_in) disable iff (sync_if.rst)
		(state_r == cfl_pkg::ST_STREAM && sync_if.sel) [*4]);
	c_latch_mode: cover property (@(posedge configuration_clock_in) disable iff (sync_if.rst)
		(state_r == cfl_pkg::ST_LATCH) ##1 (state_r == cfl_pkg::ST_STREAM));
	c_reselect: cover property (@(posedge configuration_clock_in) disable iff (sync_if.rst)
		(state_r == cfl_pkg::ST_STREAM) ##1 (state_r == cfl_pkg::ST_DESEL) ##[1:20]
		(state_r == cfl_pkg::ST_STREAM));
	c_status_seen: cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(stream_active_out));
endmodule
`default_nettype wire

// ===== rtl/cfl_link_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for all levels entering the configuration clock domain
module cfl_link_sync
(
	input wire logic link_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic chip_select_n_in,
	input wire logic latch_enable_n_in,
	input wire logic [cfl_pkg::ADDR_W-1:0] address_in,
	cfl_sync_if.sync_side sync_if
);
	localparam int W = cfl_pkg::ADDR_W + 4;

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] hold_r;
	logic [W-1:0] hold_nxt;

	// select and latch enable are inverted here so the port sees active-high levels
	always_comb
	begin
		meta_nxt = {rst_in, ce_in, ~chip_select_n_in, ~latch_enable_n_in, address_in};
		hold_nxt = meta_r;
	end

	// first stage feeds only the second; the address is quasi-static while latched
	always_ff @(posedge link_clk_in)
	begin
		meta_r <= meta_nxt;
		hold_r <= hold_nxt;
	end

	assign sync_if.rst = hold_r[W-1];
	assign sync_if.ce = hold_r[W-2];
	assign sync_if.sel = hold_r[W-3];
	assign sync_if.latch_low = hold_r[W-4];
	assign sync_if.addr = hold_r[cfl_pkg::ADDR_W-1:0];
endmodule
`default_nettype wire

// ===== rtl/cfl_pkg.sv
package cfl_pkg;
	// word and address widths of the flash array port
	localparam int DATA_W = 16;
	localparam int ADDR_W = 23;
	// words actually stored; the address counter keeps its full width
	localparam int MEM_AW = 10;
	localparam int MEM_DEPTH = 1 << MEM_AW;
	// address the counter takes when the address lines rest low
	localparam logic [ADDR_W-1:0] START_ADDR = 23'h00_0000;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 23'h00_0001;
	// output enable polarity on the data pins: low while driving
	localparam logic OE_DRIVE = 1'b0;
	localparam logic OE_RELEASE = 1'b1;
	localparam logic [DATA_W-1:0] DATA_IDLE = 16'h0000;
	// synchroniser depth for everything entering the link domain
	localparam int SYNC_STAGES = 2;

	// link-side states of the read port
	typedef enum logic [2:0]
	{
		ST_DESEL = 3'h1,
		ST_STREAM = 3'h2,
		ST_LATCH = 3'h4
	} cfl_state_t;
endpackage

// ===== rtl/cfl_sync_if.sv
`timescale 1ns/100ps
`default_nettype none
// synchronised pin levels handed from the input stage to the read port
interface cfl_sync_if;
	logic rst;
	logic ce;
	logic sel;
	logic latch_low;
	logic [cfl_pkg::ADDR_W-1:0] addr;

	modport sync_side
	(
		output rst,
		output ce,
		output sel,
		output latch_low,
		output addr
	);
	modport port_side
	(
		input rst,
		input ce,
		input sel,
		input latch_low,
		input addr
	);
endinterface
`default_nettype wire

// ===== verification/cfl_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// configuring side: makes the link clock, drives select, latch and address, captures words
module cfl_host_model
(
	output var logic lclk_out,
	output var logic sel_n_out,
	output var logic latch_n_out,
	output var logic [cfl_pkg::ADDR_W-1:0] addr_out,
	input wire logic [cfl_pkg::DATA_W-1:0] dq_in,
	input wire logic dq_oe_n_in
);
	logic clk_on;
	logic [cfl_pkg::DATA_W-1:0] got[$];
	// host configuration pins that never reach the port; kept to model the host side
	logic cfg_busy;
	logic cfg_done;
	logic cfg_sel_n;
	logic config_direction_n;

	// link clock runs from the start, then only from a drive call until the next stop, so a port leaning on a free clock shows up
	initial
	begin
		lclk_out = 1'b0;
		clk_on = 1'b1;
		sel_n_out = 1'b1;
		latch_n_out = 1'b1;
		addr_out = '0;
		cfg_busy = 1'b0;
		cfg_done = 1'b0;
		cfg_sel_n = 1'b0;
		config_direction_n = 1'b0;
		#2.3;
		forever
		begin
			#6;
			if (clk_on)
				lclk_out = ~lclk_out;
		end
	end

	// pins change just after a link edge and stand until the next call
	task drive(input logic sel_n, input logic lat_n, input logic [cfl_pkg::ADDR_W-1:0] a);
		clk_on = 1'b1;
		@(posedge lclk_out);
		#1;
		// an asynchronous accessor only runs once done has been released high
		if (!lat_n)
			cfg_done = 1'b1;
		sel_n_out = sel_n;
		latch_n_out = lat_n;
		addr_out = a;
	endtask

	// take a word on each rising link edge while the port drives; bounded wait
	task grab(input int n);
		int w;
		w = 0;
		got.delete();
		while (got.size() < n && w < 40)
		begin
			@(posedge lclk_out);
			w++;
			if (dq_oe_n_in === cfl_pkg::OE_DRIVE)
				got.push_back(dq_in);
		end
	endtask
endmodule
`default_nettype wire

// ===== verification/test_config_flash_control_signaling.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
		end \
	end
module test_config_flash_control_signaling;
	logic clk_sys, rst, ce, we, lclk, sel_n, lat_n, oe_n, active;
	logic [cfl_pkg::ADDR_W-1:0] addr;
	logic [cfl_pkg::MEM_AW-1:0] paddr;
	logic [cfl_pkg::DATA_W-1:0] pdata, dq;
	logic [cfl_pkg::DATA_W-1:0] q[$];
	int n_mismatch = 0;
	int samples_checked = 0;

	cfl_flash_port cfl_flash_port_inst
	(
		.clk_sys_in(clk_sys), .rst_in(rst), .ce_in(ce), .configuration_clock_in(lclk),
		.chip_select_n_in(sel_n), .latch_enable_n_in(lat_n), .address_in(addr),
		.dq_in(16'h0000), .dq_out(dq), .dq_oe_n_out(oe_n), .prog_we_in(we),
		.prog_addr_in(paddr), .prog_data_in(pdata), .stream_active_out(active)
	);
	cfl_host_model cfl_host_model_inst
	(
		.lclk_out(lclk), .sel_n_out(sel_n), .latch_n_out(lat_n), .addr_out(addr),
		.dq_in(dq), .dq_oe_n_in(oe_n)
	);

	// system clock, 10 ns
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	function automatic logic [15:0] word(input int i);
		return 16'h5a00 + 16'(i);
	endfunction

	task conclude();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// a short capture means the port stalled: give up at once
	task take(input int n);
		cfl_host_model_inst.grab(n);
		q = cfl_host_model_inst.got;
		if (q.size() < n)
		begin
			n_mismatch++;
			conclude();
		end
	endtask

	task load(input int i, input logic [15:0] d);
		@(posedge clk_sys);
		#1;
		we = 1'b1;
		paddr = 10'(i);
		pdata = d;
		@(posedge clk_sys);
		#1;
		we = 1'b0;
	endtask

	// deselect; the port must let go of the data lines within a few link edges
	task stop();
		cfl_host_model_inst.drive(1'b1, 1'b1, '0);
		repeat (6) @(posedge lclk);
		`CHK(oe_n, cfl_pkg::OE_RELEASE)
		repeat (8) @(posedge clk_sys);
		`CHK(active, 1'b0)
		cfl_host_model_inst.clk_on = 1'b0;
	endtask

	task t_stream();
		ce = 1'b0;
		load(3, 16'hdead);
		ce = 1'b1;
		cfl_host_model_inst.drive(1'b0, 1'b1, '0);
		take(4);
		`CHK(q[0], word(0))
		`CHK(q[1], word(1))
		`CHK(q[2], word(2))
		`CHK(q[3], word(3))
		`CHK(active, 1'b1)
		cfl_host_model_inst.drive(1'b0, 1'b1, 23'h00_0007);
		take(4);
		`CHK(q[0], word(5))
		`CHK(q[3], word(8))
		stop();
		$display("t_stream done");
	endtask

	task t_latch_off();
		cfl_host_model_inst.drive(1'b1, 1'b0, 23'h00_0009);
		repeat (5) @(posedge lclk);
		`CHK(oe_n, cfl_pkg::OE_RELEASE)
		cfl_host_model_inst.drive(1'b1, 1'b1, '0);
		cfl_host_model_inst.drive(1'b0, 1'b1, '0);
		take(2);
		`CHK(q[0], word(0))
		`CHK(q[1], word(1))
		stop();
		$display("t_latch_off done");
	endtask

	// transparent latch: with steady lines the same word keeps coming
	task t_latch_on();
		cfl_host_model_inst.drive(1'b0, 1'b1, '0);
		take(2);
		cfl_host_model_inst.drive(1'b0, 1'b0, 23'h00_000c);
		take(6);
		`CHK(q[5], word(12))
		stop();
		$display("t_latch_on done");
	endtask

	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		we = 1'b0;
		paddr = '0;
		pdata = '0;
		repeat (16) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 16; i++)
			load(i, word(i));
		t_stream();
		t_latch_off();
		t_latch_on();
		conclude();
	end

	// hang guard
	initial
	begin
		#200000;
		n_mismatch++;
		conclude();
	end
endmodule
`default_nettype wire
